// File: brake_protect.sv
`default_nettype none
module brake_protect
    import brake_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC,
    parameter int RES_OVL_COUNT = RES_OVL_TICKS
) (
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [10:0] DC_LINK_V_I,
    input wire logic [16:0] RES_POWER_I,
    input wire logic [15:0] MOTOR_CUR_I,
    input wire logic [7:0] OUT_FREQ_I,
    input wire logic [13:0] PTC_MV_I,
    output logic BRAKE_ON_O,
    output logic PWM_ENABLE_O,
    output logic PTC_SRC_EN_O,
    output logic [11:0] PTC_SRC_UA_O,
    output logic FAULT_O,
    output logic ALARM_O,
    output logic [15:0] THERM_IMAGE_O
);
    function automatic logic [10:0] ov_trip(input logic [3:0] cls);
        logic [10:0] lvl;
        case (cls)
            4'h0: lvl = OV_TRIP_C0;
            4'h1, 4'h2, 4'h3, 4'h4: lvl = OV_TRIP_C1;
            4'h5, 4'h6, 4'h7: lvl = OV_TRIP_C5;
            default: lvl = OV_TRIP_C8;
        endcase
        return lvl;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    meas_type meas_raw;
    meas_type meas;
    logic tick;
    logic res_done;
    wire logic res_over;

    assign meas_raw = '{dc_v: DC_LINK_V_I, res_pwr: RES_POWER_I,
        mot_cur: MOTOR_CUR_I, freq_pct: OUT_FREQ_I, ptc_mv: PTC_MV_I};

    in_sync #(.W($bits(meas_type))) u_sync (
        .clk_i(CLK_SYS_I),
        .rst_i(SYS_RST_I),
        .d_i(meas_raw),
        .q_o(meas)
    );

    persist_timer #(.TICK_CYCLES(TICK_CYCLES), .COUNT(RES_OVL_COUNT)) u_res (
        .clk_i(CLK_SYS_I),
        .rst_i(SYS_RST_I),
        .cond_i(res_over),
        .tick_o(tick),
        .done_o(res_done)
    );

    ////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl_reg;
    logic [10:0] brk_lvl_reg;
    logic [12:0] brk_res_reg;
    logic [16:0] brk_pwr_reg;
    logic [15:0] rated_reg;
    logic [15:0] sf_reg;
    logic [7:0] ovl_alm_reg;
    logic [15:0] image_reg;
    logic [15:0] image_next;
    status_type stat_reg;
    status_type stat_next;
    wire logic acc;
    wire logic wr;
    wire logic hit;
    wire logic [3:0] line_class;
    wire react_type react;
    wire logic [4:0] ai_func;
    wire logic [4:0] ao_func;
    wire logic auto_reset;
    logic [31:0] rd_data;
    status_type clr;

    assign acc = PSEL_I && PENABLE_I && !PREADY_O;
    assign wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !PSLVERR_O;
    assign line_class = ctrl_reg[CTRL_CLASS_LSB +: 4];
    assign react = react_type'(ctrl_reg[CTRL_REACT_LSB +: 2]);
    assign ai_func = ctrl_reg[CTRL_AI_LSB +: 5];
    assign ao_func = ctrl_reg[CTRL_AO_LSB +: 5];
    assign auto_reset = ctrl_reg[CTRL_AUTO_BIT];
    assign hit = PADDR_I inside {ADR_CTRL, ADR_BRK_LVL, ADR_BRK_RES,
        ADR_BRK_PWR, ADR_MOTOR, ADR_OVL_ALM, ADR_THERM, ADR_STATUS};

    always_comb begin
        case (PADDR_I)
            ADR_CTRL: rd_data = ctrl_reg;
            ADR_BRK_LVL: rd_data = {21'h0, brk_lvl_reg};
            ADR_BRK_RES: rd_data = {19'h0, brk_res_reg};
            ADR_BRK_PWR: rd_data = {15'h0, brk_pwr_reg};
            ADR_MOTOR: rd_data = {sf_reg, rated_reg};
            ADR_OVL_ALM: rd_data = {24'h0, ovl_alm_reg};
            ADR_THERM: rd_data = {16'h0, image_reg};
            ADR_STATUS: rd_data = {26'h0, stat_reg};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    assign clr = (wr && PADDR_I == ADR_STATUS)
        ? status_type'(PWDATA_I[5:0]) : '0;

    // One wait state: PREADY rises on the edge that ends the first access cycle, and the
    // write lands on the edge where the master sees it high.
    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
        end else begin
            PREADY_O <= acc;
            PSLVERR_O <= acc && !hit;
            PRDATA_O <= (acc && !PWRITE_I) ? rd_data : 32'h0000_0000;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ctrl_reg <= CTRL_RST;
            brk_lvl_reg <= BRK_LVL_RST;
            brk_res_reg <= BRK_RES_RST;
            brk_pwr_reg <= BRK_PWR_RST;
            rated_reg <= RATED_RST;
            sf_reg <= SF_RST;
            ovl_alm_reg <= OVL_ALM_RST;
        end else if (wr) begin
            case (PADDR_I)
                ADR_CTRL: ctrl_reg <= PWDATA_I;
                ADR_BRK_LVL: brk_lvl_reg <= PWDATA_I[10:0];
                ADR_BRK_RES: brk_res_reg <= PWDATA_I[12:0];
                ADR_BRK_PWR: brk_pwr_reg <= PWDATA_I[16:0];
                ADR_MOTOR: {sf_reg, rated_reg} <= PWDATA_I;
                ADR_OVL_ALM: ovl_alm_reg <= PWDATA_I[7:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    wire logic dc_over_brk;
    wire logic dc_over_trip;

    assign dc_over_brk = meas.dc_v > brk_lvl_reg;
    assign dc_over_trip = meas.dc_v > ov_trip(line_class);
    assign res_over = (brk_res_reg != '0)
        && (meas.res_pwr > brk_pwr_reg);

    ////////////////////////////////////////////////////////////////////////
    // Thermal image: 16-bit heat store, full scale is the trip point.
    wire logic [15:0] trip_cur;
    wire logic above_sf;
    wire logic heating;
    wire logic [15:0] heat;
    wire logic [1:0] speed_shift;
    wire logic hot;
    wire logic [18:0] heat_scaled;
    wire logic [19:0] image_sum;
    wire logic image_full;
    wire logic ovl_fault_en;
    wire logic ovl_alarm_en;
    wire logic therm_wr;

    assign trip_cur = rated_reg + {2'b00, rated_reg[15:2]};
    assign above_sf = 32'(meas.mot_cur) * 32'(PCT_SCALE)
        > 32'(rated_reg) * 32'(sf_reg);
    assign heating = above_sf && meas.mot_cur > trip_cur;
    assign heat = meas.mot_cur - trip_cur;
    assign speed_shift = (meas.freq_pct < FREQ_LOW_PCT) ? 2'd2
        : (meas.freq_pct < FREQ_HALF_PCT) ? 2'd1 : 2'd0;
    assign hot = image_reg[15];
    assign heat_scaled = {3'b000, heat} << (speed_shift + {1'b0, hot});
    assign image_sum = {4'h0, image_reg} + {1'b0, heat_scaled};
    assign image_full = image_reg == 16'hffff;
    assign ovl_fault_en = react == REACT_BOTH
        || react == REACT_FAULT;
    assign ovl_alarm_en = react == REACT_BOTH
        || react == REACT_ALARM;
    assign therm_wr = wr && PADDR_I == ADR_THERM;

    always_comb begin
        image_next = image_reg;
        if (therm_wr) begin
            image_next = PWDATA_I[15:0];
        end else if (tick && heating) begin
            image_next = (image_sum > 20'h0ffff) ? 16'hffff : image_sum[15:0];
        end else if (tick && image_reg >= COOL_STEP) begin
            image_next = image_reg - COOL_STEP;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    wire logic ptc_used;
    wire logic ptc_ok;
    wire logic ptc_alarm_set;
    wire logic ptc_fault_set;

    assign ptc_used = ai_func == AI_FUNC_PTC;
    assign ptc_ok = meas.ptc_mv > PTC_OK_LO_MV
        && meas.ptc_mv < PTC_OK_HI_MV;
    assign ptc_alarm_set = ptc_used && meas.ptc_mv > PTC_ALM_MV;
    assign ptc_fault_set = ptc_used && (meas.ptc_mv > PTC_FLT_MV
        || meas.ptc_mv < PTC_SHORT_MV);

    // Faults are sticky, except ot_fault with auto_reset set; a set in the same cycle as a clear wins.
    always_comb begin
        stat_next = stat_reg;
        stat_next.ov_fault = dc_over_trip
            || (stat_reg.ov_fault && !clr.ov_fault);
        // A done pulse left over from before the resistance was zeroed
        // must not set the fault once supervision is off.
        stat_next.res_fault = (res_done && brk_res_reg != '0)
            || (stat_reg.res_fault && !clr.res_fault);
        stat_next.ovl_fault = (ovl_fault_en && image_full && above_sf)
            || (stat_reg.ovl_fault && !clr.ovl_fault);
        stat_next.ovl_alarm = ovl_alarm_en
            && image_reg[15:8] >= ovl_alm_reg;
        // The shorted-sensor and hot reset windows never overlap, so a
        // clear can only succeed with the sensor back in normal range.
        if (ptc_fault_set) begin
            stat_next.ot_fault = 1'b1;
        end else if (ptc_ok && (clr.ot_fault || auto_reset)) begin
            stat_next.ot_fault = 1'b0;
        end
        if (!ptc_used) begin
            stat_next.ot_alarm = 1'b0;
        end else if (ptc_alarm_set) begin
            stat_next.ot_alarm = 1'b1;
        end else if (ptc_ok) begin
            stat_next.ot_alarm = 1'b0;
        end
    end

    wire logic fault_any_next;
    wire logic alarm_any_next;

    assign fault_any_next = stat_next.ov_fault || stat_next.res_fault
        || stat_next.ovl_fault || stat_next.ot_fault;
    assign alarm_any_next = stat_next.ovl_alarm || stat_next.ot_alarm;

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            stat_reg <= '0;
            image_reg <= 16'h0000;
            BRAKE_ON_O <= 1'b0;
            PWM_ENABLE_O <= 1'b0;
            PTC_SRC_EN_O <= 1'b0;
            PTC_SRC_UA_O <= 12'h000;
            FAULT_O <= 1'b0;
            ALARM_O <= 1'b0;
            THERM_IMAGE_O <= 16'h0000;
        end else begin
            stat_reg <= stat_next;
            image_reg <= image_next;
            BRAKE_ON_O <= dc_over_brk && !fault_any_next;
            PWM_ENABLE_O <= !fault_any_next;
            PTC_SRC_EN_O <= ao_func == AO_FUNC_PTC;
            PTC_SRC_UA_O <= (ao_func == AO_FUNC_PTC) ? PTC_SRC_UA : 12'h000;
            FAULT_O <= fault_any_next;
            ALARM_O <= alarm_any_next;
            THERM_IMAGE_O <= image_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    wire logic any_fault;
    assign any_fault = stat_reg.ov_fault || stat_reg.res_fault
        || stat_reg.ovl_fault || stat_reg.ot_fault;

    property p_brake_cause;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        BRAKE_ON_O |-> $past(dc_over_brk) && !any_fault;
    endproperty
    a_brake_cause: assert property (p_brake_cause)
        else $error("brake switch on without cause");

    property p_ov_trip;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        dc_over_trip |=> stat_reg.ov_fault && !PWM_ENABLE_O;
    endproperty
    a_ov_trip: assert property (p_ov_trip)
        else $error("overvoltage did not trip");

    property p_res_off;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (brk_res_reg == '0 && !stat_reg.res_fault) |=> !stat_reg.res_fault;
    endproperty
    a_res_off: assert property (p_res_off)
        else $error("resistor fault with zero resistance");

    property p_fault_stop;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        any_fault |-> !PWM_ENABLE_O && !BRAKE_ON_O;
    endproperty
    a_fault_stop: assert property (p_fault_stop)
        else $error("pulses active during fault");

    property p_alarm_run;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (ALARM_O && !FAULT_O) |-> PWM_ENABLE_O;
    endproperty
    a_alarm_run: assert property (p_alarm_run)
        else $error("alarm stopped the output");

    property p_react_none;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (react == REACT_NONE && !stat_reg.ovl_fault)
            |=> !stat_reg.ovl_fault && !stat_reg.ovl_alarm;
    endproperty
    a_react_none: assert property (p_react_none)
        else $error("disabled overload still reacted");

    property p_sf_safe;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (!above_sf && !stat_reg.ovl_fault) |=> !stat_reg.ovl_fault;
    endproperty
    a_sf_safe: assert property (p_sf_safe)
        else $error("overload trip below service current");

    property p_ptc_src;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        PTC_SRC_EN_O |-> PTC_SRC_UA_O == PTC_SRC_UA;
    endproperty
    a_ptc_src: assert property (p_ptc_src)
        else $error("PTC source current wrong");

    property p_ot_fault;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (ptc_used && meas.ptc_mv > PTC_FLT_MV) |=> ##1 FAULT_O;
    endproperty
    a_ot_fault: assert property (p_ot_fault)
        else $error("overtemperature fault missing");

    property p_ot_hold;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (ptc_used && meas.ptc_mv >= PTC_OK_HI_MV
            && meas.ptc_mv <= PTC_ALM_MV) |=> $stable(stat_reg.ot_alarm);
    endproperty
    a_ot_hold: assert property (p_ot_hold)
        else $error("overtemperature alarm moved in band");

    c_brake: cover property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        $rose(BRAKE_ON_O));
    c_res_fault: cover property (@(posedge CLK_SYS_I)
        disable iff (SYS_RST_I) $rose(stat_reg.res_fault));
    c_ovl_fault: cover property (@(posedge CLK_SYS_I)
        disable iff (SYS_RST_I) $rose(stat_reg.ovl_fault));
    c_ot_reset: cover property (@(posedge CLK_SYS_I)
        disable iff (SYS_RST_I) $fell(stat_reg.ot_fault));
endmodule
`default_nettype wire

// File: brake_pkg.sv
`default_nettype none
package brake_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_TIME_US;
    localparam int RES_OVL_TIME_S = 120;
    localparam int RES_OVL_TICKS = RES_OVL_TIME_S * 1_000_000 / TICK_TIME_US;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_BRK_LVL = 8'h04;
    localparam logic [7:0] ADR_BRK_RES = 8'h08;
    localparam logic [7:0] ADR_BRK_PWR = 8'h0c;
    localparam logic [7:0] ADR_MOTOR = 8'h10;
    localparam logic [7:0] ADR_OVL_ALM = 8'h14;
    localparam logic [7:0] ADR_THERM = 8'h18;
    localparam logic [7:0] ADR_STATUS = 8'h1c;
    localparam int CTRL_CLASS_LSB = 0;
    localparam int CTRL_REACT_LSB = 4;
    localparam int CTRL_AI_LSB = 8;
    localparam int CTRL_AO_LSB = 16;
    localparam int CTRL_AUTO_BIT = 24;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [10:0] BRK_LVL_RST = 11'h177;
    localparam logic [12:0] BRK_RES_RST = 13'h0000;
    localparam logic [16:0] BRK_PWR_RST = 17'h00104;
    localparam logic [15:0] RATED_RST = 16'h0064;
    localparam logic [15:0] SF_RST = 16'h0064;
    localparam logic [7:0] OVL_ALM_RST = 8'hc0;
    localparam logic [4:0] AO_FUNC_PTC = 5'h0d;
    localparam logic [4:0] AI_FUNC_PTC = 5'h04;
    localparam logic [11:0] PTC_SRC_UA = 12'h7d0;
    localparam logic [13:0] PTC_ALM_MV = 14'h1b58;
    localparam logic [13:0] PTC_FLT_MV = 14'h1e78;
    localparam logic [13:0] PTC_OK_LO_MV = 14'h012c;
    localparam logic [13:0] PTC_OK_HI_MV = 14'h0c80;
    localparam logic [13:0] PTC_SHORT_MV = 14'h0078;
    localparam logic [10:0] OV_TRIP_C0 = 11'h190;
    localparam logic [10:0] OV_TRIP_C1 = 11'h320;
    localparam logic [10:0] OV_TRIP_C5 = 11'h3e8;
    localparam logic [10:0] OV_TRIP_C8 = 11'h4b0;
    localparam logic [7:0] FREQ_HALF_PCT = 8'h32;
    localparam logic [7:0] FREQ_LOW_PCT = 8'h05;
    localparam logic [15:0] COOL_STEP = 16'h0001;
    localparam logic [6:0] PCT_SCALE = 7'h64;
    typedef enum logic [1:0] {
        REACT_BOTH, REACT_FAULT, REACT_ALARM, REACT_NONE
    } react_type;
    typedef struct packed {
        logic [10:0] dc_v;
        logic [16:0] res_pwr;
        logic [15:0] mot_cur;
        logic [7:0] freq_pct;
        logic [13:0] ptc_mv;
    } meas_type;
    typedef struct packed {
        logic ot_alarm;
        logic ovl_alarm;
        logic ot_fault;
        logic ovl_fault;
        logic res_fault;
        logic ov_fault;
    } status_type;
endpackage
`default_nettype wire

// File: in_sync.sv
`default_nettype none
module in_sync #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    generate
        if (W < 1) begin : g_chk
            $error("in_sync width must be positive");
        end
    endgenerate

    // Multi-bit values are slow analog samples; a torn word lasts one cycle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_o <= '0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// File: persist_timer.sv
`default_nettype none
module persist_timer #(
    parameter int TICK_CYCLES = 40000,
    parameter int COUNT = 120000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cond_i,
    output logic tick_o,
    output logic done_o
);
    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam int CW = $clog2(COUNT + 1);
    logic [PW-1:0] pre_reg;
    logic [CW-1:0] cnt_reg;
    wire logic pre_end;
    wire logic cnt_full;

    generate
        if (TICK_CYCLES < 1 || COUNT < 1) begin : g_chk
            $error("persist_timer counts must be positive");
        end
    endgenerate

    assign pre_end = pre_reg == PW'(TICK_CYCLES - 1);
    assign cnt_full = cnt_reg == CW'(COUNT);

    // The count restarts whenever the condition drops, so only an
    // uninterrupted stretch of the full length reports done.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_reg <= '0;
            cnt_reg <= '0;
            tick_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            pre_reg <= pre_end ? '0 : pre_reg + 1'b1;
            tick_o <= pre_end;
            if (!cond_i) begin
                cnt_reg <= '0;
            end else if (pre_end && !cnt_full) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
            done_o <= cond_i && cnt_full;
        end
    end
endmodule
`default_nettype wire

// File: meas_src.sv
`default_nettype none
module meas_src
    import brake_pkg::*;
(
    input wire logic clk_i,
    output meas_type meas_o
);
    timeunit 1ns;
    timeprecision 100ps;
    meas_type m_reg = '0;
    // The PTC sample is plain millivolts, with no gain or offset applied.
    assign meas_o = m_reg;
    // A new sample lands just after an edge, as a converter would update.
    task put(input meas_type m);
        @(posedge clk_i);
        m_reg <= m;
    endtask
endmodule
`default_nettype wire

// File: tb.sv
`default_nettype none
module tb
    import brake_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, er;
    logic [7:0] padr = '0;
    logic [31:0] pwd = '0, prd, q;
    logic pready, perr, brake, pwm, fault, alarm, src_en;
    logic [11:0] src_ua;
    logic [15:0] timg;
    meas_type m = '0, mv;
    int fails = 0, tests_run = 0;
    meas_src i_meas_src(.clk_i(clk), .meas_o(mv));
    brake_protect #(.TICK_CYCLES(4), .RES_OVL_COUNT(5)) i_brake_protect(
        .CLK_SYS_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd),
        .PREADY_O(pready), .PSLVERR_O(perr), .DC_LINK_V_I(mv.dc_v),
        .RES_POWER_I(mv.res_pwr), .MOTOR_CUR_I(mv.mot_cur),
        .OUT_FREQ_I(mv.freq_pct), .PTC_MV_I(mv.ptc_mv),
        .BRAKE_ON_O(brake), .PWM_ENABLE_O(pwm), .PTC_SRC_EN_O(src_en),
        .PTC_SRC_UA_O(src_ua), .FAULT_O(fault), .ALARM_O(alarm),
        .THERM_IMAGE_O(timg));
    initial begin
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task put();
        i_meas_src.put(m);
    endtask
    // Ready is read as the edge wakes us, before the design's updates
    // land, so it is the value that this very edge samples.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task clr_all();
        m.mot_cur = 16'h0000;
        m.res_pwr = 17'h00000;
        m.dc_v = 11'd300;
        put();
        cyc(4);
        apb(1'b1, ADR_STATUS, 32'h0000_003f);
        cyc(3);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_reset();
        apb(1'b0, ADR_BRK_LVL, 32'h0);
        chk(q, 32'h0000_0177);
        apb(1'b0, ADR_BRK_PWR, 32'h0);
        chk(q, 32'h0000_0104);
        apb(1'b0, ADR_MOTOR, 32'h0);
        chk(q, 32'h0064_0064);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("reset test done");
    endtask
    task t_brake();
        m.dc_v = 11'd376;
        put();
        cyc(5);
        chk({31'h0, brake}, 32'h1);
        m.dc_v = 11'd375;
        put();
        cyc(5);
        chk({31'h0, brake}, 32'h0);
        $display("brake test done");
    endtask
    task t_ov();
        int cls[4] = '{0, 2, 6, 8};
        int trip[4] = '{400, 800, 1000, 1200};
        foreach (cls[i]) begin
            apb(1'b1, ADR_CTRL, 32'(cls[i]));
            m.dc_v = 11'(trip[i]);
            put();
            cyc(5);
            chk({31'h0, fault}, 32'h0);
            m.dc_v = 11'(trip[i] + 1);
            put();
            cyc(5);
            chk({31'h0, fault}, 32'h1);
            chk({30'h0, pwm, brake}, 32'h0);
            clr_all();
        end
        $display("overvoltage test done");
    endtask
    task t_res();
        m.res_pwr = 17'd261;
        put();
        cyc(60);
        chk({31'h0, fault}, 32'h0);
        m.res_pwr = 17'd260;
        put();
        apb(1'b1, ADR_BRK_RES, 32'd100);
        cyc(60);
        chk({31'h0, fault}, 32'h0);
        m.res_pwr = 17'd261;
        put();
        cyc(12);
        chk({31'h0, fault}, 32'h0);
        cyc(30);
        chk({30'h0, fault, pwm}, 32'h2);
        clr_all();
        $display("resistor test done");
    endtask
    task t_mot();
        for (int r = 0; r < 4; r++) begin
            clr_all();
            apb(1'b1, ADR_CTRL, 32'(r) << 4);
            apb(1'b1, ADR_THERM, 32'h0000_ffff);
            m.mot_cur = 16'd200;
            put();
            cyc(20);
            chk({31'h0, fault}, 32'(r < 2));
            chk({31'h0, alarm}, 32'(r == 0 || r == 2));
            chk({31'h0, pwm}, 32'(r >= 2));
        end
        $display("overload reaction test done");
    endtask
    task t_speed();
        int fr[2] = '{100, 3};
        apb(1'b1, ADR_CTRL, 32'h0000_0000);
        foreach (fr[i]) begin
            clr_all();
            m.freq_pct = 8'(fr[i]);
            apb(1'b1, ADR_THERM, 32'h0000_ff00);
            m.mot_cur = 16'd126;
            put();
            cyc(300);
            chk({31'h0, fault}, 32'(fr[i] == 3));
            cyc(500);
            chk({31'h0, fault}, 32'h1);
        end
        clr_all();
        m.freq_pct = 8'd100;
        apb(1'b1, ADR_THERM, 32'h0000_ff00);
        m.mot_cur = 16'd125;
        put();
        cyc(800);
        chk({31'h0, fault}, 32'h0);
        apb(1'b1, ADR_MOTOR, 32'h0073_0064);
        m.mot_cur = 16'd115;
        put();
        cyc(3);
        apb(1'b1, ADR_THERM, 32'h0000_ffff);
        #1;
        chk({16'h0, timg}, 32'h0000_ffff);
        cyc(20);
        chk({31'h0, fault}, 32'h0);
        $display("overload curve test done");
    endtask
    task t_ptc();
        logic [13:0] v[10] = '{7000, 7001, 5000, 7800, 7801, 5000, 3200,
            3199, 120, 119};
        logic [2:0] f[10] = '{0, 2, 2, 2, 3, 7, 7, 4, 0, 1};
        clr_all();
        apb(1'b1, ADR_THERM, 32'h0);
        m.ptc_mv = 14'd7900;
        put();
        cyc(5);
        chk({31'h0, fault}, 32'h0);
        m.ptc_mv = 14'd5000;
        put();
        apb(1'b1, ADR_CTRL, 32'h000d_0400);
        cyc(3);
        chk({19'h0, src_en, src_ua}, 32'h0000_17d0);
        foreach (v[i]) begin
            m.ptc_mv = v[i];
            put();
            cyc(5);
            if (f[i][2])
                apb(1'b1, ADR_STATUS, 32'h0000_0008);
            cyc(3);
            chk({31'h0, alarm}, 32'(f[i][1]));
            chk({31'h0, fault}, 32'(f[i][0]));
            chk({31'h0, pwm}, 32'(!f[i][0]));
        end
        m.ptc_mv = 14'd5000;
        put();
        apb(1'b1, ADR_CTRL, 32'h010d_0400);
        cyc(10);
        chk({31'h0, fault}, 32'h1);
        m.ptc_mv = 14'd2000;
        put();
        cyc(10);
        chk({31'h0, fault}, 32'h0);
        $display("overtemperature test done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    task results();
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        m.freq_pct = 8'd100;
        m.dc_v = 11'd300;
        put();
        @(posedge clk);
        rst <= 1'b0;
        cyc(3);
        t_reset();
        t_brake();
        t_ov();
        t_res();
        t_mot();
        t_speed();
        t_ptc();
        results();
    end
    // The whole sequence needs about 3100 cycles.
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        results();
    end
endmodule
`default_nettype wire
